// >>> verilog/operate_pkg.sv
package operate_pkg;

   // Data path width and APB address width
   localparam int WORD_W = 12;
   localparam int ADDR_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] INSTR_OFS  = 8'h00;
   localparam logic [ADDR_W-1:0] ACC1_OFS   = 8'h04;
   localparam logic [ADDR_W-1:0] ACC2_OFS   = 8'h08;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;
   localparam logic [ADDR_W-1:0] PC_OFS     = 8'h10;

   // Status register bit positions
   localparam int ST_FLAG_BIT  = 0;
   localparam int ST_OVF_BIT   = 1;
   localparam int ST_BUSY_BIT  = 2;
   localparam int ST_SKIP_BIT  = 3;
   localparam int ST_NONOP_BIT = 4;

   // Reset values
   localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
   localparam logic              BIT_RST  = 1'b0;

   // Instruction bit positions, bit 0 is the most significant
   localparam int IB_OP0      = 0;
   localparam int IB_OP1      = 1;
   localparam int IB_OP2      = 2;
   localparam int IB_OP3      = 3;
   localparam int IB_SEC_SEL  = 4;
   localparam int IB_FIRST_SEL = 5;
   localparam int IB_OVF_SEL  = 6;
   localparam int IB_INVERT   = 7;
   localparam int IB_CLEAR    = 8;
   localparam int IB_REVERSE  = 9;
   localparam int IB_SIGN     = 10;
   localparam int IB_ZERO     = 11;

   // Clock cycles per timing period
   localparam int PERIOD_STEP_CYCLES = 4;

   // Timing periods of one operate instruction
   typedef enum logic [3:0] {
      PER_IDLE,
      PER_PRE_CLEAR,
      PER_SECOND_ROUTE,
      PER_SECOND_CARRY,
      PER_SECOND_LOAD,
      PER_FIRST_ROUTE,
      PER_FIRST_CARRY,
      PER_FIRST_LOAD,
      PER_SKIP_TEST
   } period_e;

   // Instruction bit in left-to-right numbering
   function automatic logic ibit(input logic [WORD_W-1:0] w, input int n);
      return w[WORD_W-1-n];
   endfunction : ibit

endpackage : operate_pkg

// >>> verilog/alu_if.sv
`timescale 1ns/1ps
interface alu_if #(
   parameter int W = 12
);
   logic [W-1:0] operand;
   logic [W-1:0] aux;
   logic         invert;
   logic         carry_in;
   logic [W-1:0] sum;

   modport ctrl (output operand, output aux, output invert, output carry_in, input sum);
   modport unit (input operand, input aux, input invert, input carry_in, output sum);
endinterface : alu_if

// >>> verilog/operate_adder.sv
`timescale 1ns/1ps
module operate_adder #(
   parameter int W = 12
) (
   alu_if.unit bus
);
   logic [W-1:0] passed;

   // Add-subtract logic passes operand straight or inverted
   assign passed = bus.invert ? ~bus.operand : bus.operand;

   // Adder wraps at the word width
   assign bus.sum = passed + bus.aux + {{(W-1){1'b0}}, bus.carry_in};
endmodule : operate_adder

// >>> verilog/accumulator_operate_decode.sv
`timescale 1ns/1ps
module accumulator_operate_decode #(
   parameter int STEP_DIV = operate_pkg::PERIOD_STEP_CYCLES
) (
   input  logic                             ref_clk_i,
   input  logic                             rst_n_i,
   input  logic                             psel_i,
   input  logic                             penable_i,
   input  logic                             pwrite_i,
   input  logic [operate_pkg::ADDR_W-1:0]   paddr_i,
   input  logic [31:0]                      pwdata_i,
   output logic [31:0]                      prdata_o,
   output logic                             pready_o,
   output logic                             pslverr_o,
   output logic                             busy_o,
   output logic [operate_pkg::WORD_W-1:0]   pc_o
);
   import operate_pkg::*;

   logic [WORD_W-1:0] instr_r;
   logic [WORD_W-1:0] acc1_r;
   logic [WORD_W-1:0] acc2_r;
   logic [WORD_W-1:0] pc_r;
   logic [WORD_W-1:0] operand_r;
   logic [WORD_W-1:0] sum_r;
   logic              flag_r;
   logic              ovf_r;
   logic              skip_r;
   logic              nonop_r;
   logic              busy_r;
   logic              start_r;
   period_e           state_r;
   period_e           state_nxt;
   logic [15:0]       div_cnt_r;
   logic              step_r;
   logic              pready_r;
   logic              pslverr_r;
   logic [31:0]       prdata_r;
   logic [31:0]       rd_data;
   logic [31:0]       status_word;
   logic              addr_hit;
   logic              wr_fire;
   logic              operate_group2_decode_n;
   logic              operate_group2_decode;
   logic              first_accum_select;
   logic              second_accum_select;
   logic              status_sel;
   logic              flag_sel;
   logic              ovf_sel;
   logic              instr_bit_eight;
   logic              invert_bit;
   logic              b9;
   logic              b10;
   logic              b11;
   logic              inc_req;
   logic              acc_mod;
   logic              accum_clear_strobe;
   logic              carry_period;
   logic              skip_cond;
   logic              status_bit;

   alu_if #(.W(WORD_W)) alu_bus ();

   // Skip test on one register: sign is msb, zero is all clear
   function automatic logic skip_hit(input logic msb, input logic zero,
                                     input logic rev, input logic sgn, input logic zt);
      logic t_sign;
      logic t_zero;
      t_sign = rev ? msb : ~msb;
      t_zero = rev ? zero : ~zero;
      return (~sgn | t_sign) & (~zt | t_zero);
   endfunction : skip_hit

   assign operate_group2_decode_n = ~(ibit(instr_r, IB_OP2) & ibit(instr_r, IB_OP3) &
                                      ~ibit(instr_r, IB_OP0) & ~ibit(instr_r, IB_OP1));
   assign operate_group2_decode = ~operate_group2_decode_n;

   assign first_accum_select  = operate_group2_decode & ibit(instr_r, IB_FIRST_SEL);
   assign second_accum_select = operate_group2_decode & ibit(instr_r, IB_SEC_SEL);
   assign status_sel = operate_group2_decode & ~ibit(instr_r, IB_SEC_SEL) &
                       ~ibit(instr_r, IB_FIRST_SEL);
   assign flag_sel   = status_sel & ~ibit(instr_r, IB_OVF_SEL);
   assign ovf_sel    = status_sel & ibit(instr_r, IB_OVF_SEL);

   assign instr_bit_eight = operate_group2_decode & ibit(instr_r, IB_CLEAR);
   assign invert_bit      = operate_group2_decode & ibit(instr_r, IB_INVERT);
   assign b9  = ibit(instr_r, IB_REVERSE);
   assign b10 = ibit(instr_r, IB_SIGN);
   assign b11 = ibit(instr_r, IB_ZERO);
   assign inc_req = operate_group2_decode & b9 & ~b10 & ~b11;
   // modify steps run when invert, clear or increment is set; increment is bit 9 with bits 10 and 11 clear
   assign acc_mod = invert_bit | instr_bit_eight | inc_req;

   assign accum_clear_strobe = step_r & (state_r == PER_PRE_CLEAR);
   assign carry_period = (state_r == PER_SECOND_CARRY) || (state_r == PER_FIRST_CARRY);
   assign status_bit = ovf_sel ? ovf_r : flag_r;

   // Adder control
   assign alu_bus.operand  = operand_r;
   assign alu_bus.aux      = '0;
   // invert and carry only in carry period
   assign alu_bus.invert   = carry_period & invert_bit;
   assign alu_bus.carry_in = carry_period & inc_req;

   operate_adder #(.W(WORD_W)) u_adder (
      .bus (alu_bus.unit)
   );

   // sign and zero tests, bit 9 reverses
   // zero and nonzero sense of bit 11
   always_comb begin
      skip_cond = operate_group2_decode & (b10 | b11);
      if (first_accum_select) begin
         skip_cond = skip_cond & skip_hit(acc1_r[WORD_W-1], acc1_r == '0, b9, b10, b11);
      end
      if (second_accum_select) begin
         skip_cond = skip_cond & skip_hit(acc2_r[WORD_W-1], acc2_r == '0, b9, b10, b11);
      end
      if (status_sel) begin
         skip_cond = skip_cond & skip_hit(status_bit, ~status_bit, b9, b10, b11);
      end
   end

   // Period step divider
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         div_cnt_r <= '0;
         step_r    <= 1'b0;
      end else if (div_cnt_r == 16'(STEP_DIV - 1)) begin
         div_cnt_r <= '0;
         step_r    <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 16'h0001;
         step_r    <= 1'b0;
      end
   end

   // Period order
   // second accumulator slots, then first
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         PER_IDLE:         state_nxt = start_r ? PER_PRE_CLEAR : PER_IDLE;
         PER_PRE_CLEAR:    state_nxt = PER_SECOND_ROUTE;
         PER_SECOND_ROUTE: state_nxt = PER_SECOND_CARRY;
         PER_SECOND_CARRY: state_nxt = PER_SECOND_LOAD;
         PER_SECOND_LOAD:  state_nxt = PER_FIRST_ROUTE;
         PER_FIRST_ROUTE:  state_nxt = PER_FIRST_CARRY;
         PER_FIRST_CARRY:  state_nxt = PER_FIRST_LOAD;
         PER_FIRST_LOAD:   state_nxt = PER_SKIP_TEST;
         PER_SKIP_TEST:    state_nxt = PER_IDLE;
      endcase
   end

   // Period register, moves on each step
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_r <= PER_IDLE;
      end else if (step_r) begin
         state_r <= state_nxt;
      end
   end

   // Read decode
   always_comb begin
      status_word = '0;
      status_word[ST_FLAG_BIT]  = flag_r;
      status_word[ST_OVF_BIT]   = ovf_r;
      status_word[ST_BUSY_BIT]  = busy_r;
      status_word[ST_SKIP_BIT]  = skip_r;
      status_word[ST_NONOP_BIT] = nonop_r;
      addr_hit = 1'b1;
      rd_data  = '0;
      unique case (paddr_i)
         INSTR_OFS:  rd_data = 32'(instr_r);
         ACC1_OFS:   rd_data = 32'(acc1_r);
         ACC2_OFS:   rd_data = 32'(acc2_r);
         STATUS_OFS: rd_data = status_word;
         PC_OFS:     rd_data = 32'(pc_r);
         default:    addr_hit = 1'b0;
      endcase
   end

   // APB answer, one wait state; writes refused while busy
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= '0;
      end else begin
         pready_r <= psel_i & penable_i & ~pready_r;
         if (psel_i & penable_i & ~pready_r) begin
            pslverr_r <= ~addr_hit | (pwrite_i & busy_r);
            prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_data;
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   assign wr_fire = psel_i & penable_i & pready_r & pwrite_i & ~pslverr_r;

   // Instruction register and start request
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         instr_r <= WORD_RST;
         start_r <= BIT_RST;
      end else if (wr_fire && paddr_i == INSTR_OFS) begin
         instr_r <= pwdata_i[WORD_W-1:0];
         start_r <= 1'b1;
      end else if (step_r && state_r == PER_IDLE) begin
         start_r <= 1'b0;
      end
   end

   // Busy from write until skip test period ends
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         busy_r <= BIT_RST;
      end else if (wr_fire && paddr_i == INSTR_OFS) begin
         busy_r <= 1'b1;
      end else if (step_r && state_r == PER_SKIP_TEST) begin
         busy_r <= 1'b0;
      end
   end

   // Operand multiplexer
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         operand_r <= WORD_RST;
      end else if (step_r && state_r == PER_SECOND_ROUTE && second_accum_select && acc_mod) begin
         operand_r <= acc2_r;
      end else if (step_r && state_r == PER_FIRST_ROUTE && first_accum_select && acc_mod) begin
         operand_r <= acc1_r;
      end
   end

   // Adder result held over to the load period
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         sum_r <= WORD_RST;
      end else if (step_r && carry_period) begin
         sum_r <= alu_bus.sum;
      end
   end

   // First accumulator
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         acc1_r <= WORD_RST;
      end else if (wr_fire && paddr_i == ACC1_OFS) begin
         acc1_r <= pwdata_i[WORD_W-1:0];
      end else if (accum_clear_strobe && instr_bit_eight && first_accum_select) begin
         acc1_r <= '0;
      end else if (step_r && state_r == PER_FIRST_LOAD && first_accum_select && acc_mod) begin
         acc1_r <= sum_r;
      end
   end

   // Second accumulator
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         acc2_r <= WORD_RST;
      end else if (wr_fire && paddr_i == ACC2_OFS) begin
         acc2_r <= pwdata_i[WORD_W-1:0];
      end else if (accum_clear_strobe && instr_bit_eight && second_accum_select) begin
         acc2_r <= '0;
      end else if (step_r && state_r == PER_SECOND_LOAD && second_accum_select && acc_mod) begin
         acc2_r <= sum_r;
      end
   end

   // Flag register: clear then invert gives set
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         flag_r <= BIT_RST;
      end else if (wr_fire && paddr_i == STATUS_OFS) begin
         flag_r <= pwdata_i[ST_FLAG_BIT];
      end else if (accum_clear_strobe && instr_bit_eight && flag_sel) begin
         flag_r <= 1'b0;
      end else if (step_r && state_r == PER_FIRST_CARRY && invert_bit && flag_sel) begin
         flag_r <= ~flag_r;
      end
   end

   // Overflow register
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ovf_r <= BIT_RST;
      end else if (wr_fire && paddr_i == STATUS_OFS) begin
         ovf_r <= pwdata_i[ST_OVF_BIT];
      end else if (accum_clear_strobe && instr_bit_eight && ovf_sel) begin
         ovf_r <= 1'b0;
      end else if (step_r && state_r == PER_FIRST_CARRY && invert_bit && ovf_sel) begin
         ovf_r <= ~ovf_r;
      end
   end

   // Program counter and skip result
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pc_r    <= WORD_RST;
         skip_r  <= BIT_RST;
         nonop_r <= BIT_RST;
      end else if (wr_fire && paddr_i == PC_OFS) begin
         pc_r <= pwdata_i[WORD_W-1:0];
      end else if (step_r && state_r == PER_SKIP_TEST) begin
         pc_r    <= pc_r + {{(WORD_W-1){1'b0}}, 1'b1} + {{(WORD_W-1){1'b0}}, skip_cond};
         skip_r  <= skip_cond;
         nonop_r <= operate_group2_decode_n;
      end
   end

   // Outputs
   assign prdata_o  = prdata_r;
   assign pready_o  = pready_r;
   assign pslverr_o = pslverr_r;
   assign busy_o    = busy_r;
   assign pc_o      = pc_r;

endmodule : accumulator_operate_decode

// >>> sim/operate_asserts.sv
`timescale 1ns/1ps
module operate_asserts
   import operate_pkg::*;
#(
   parameter int STEP_DIV = 4
) (
   input logic                            ref_clk_i,
   input logic                            rst_n_i,
   input logic                            psel_i,
   input logic                            penable_i,
   input logic                            pwrite_i,
   input logic [operate_pkg::ADDR_W-1:0]  paddr_i,
   input logic [31:0]                     pwdata_i,
   input logic [31:0]                     prdata_o,
   input logic                            pready_o,
   input logic                            pslverr_o,
   input logic                            busy_o,
   input logic [operate_pkg::WORD_W-1:0]  pc_o
);
   localparam int BUSY_MAX = 10 * STEP_DIV + 2;
   logic [WORD_W-1:0] pc_start_r;
   logic              mapped;

   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Address lands on a register
   assign mapped = paddr_i inside {INSTR_OFS, ACC1_OFS, ACC2_OFS, STATUS_OFS, PC_OFS};

   // Counter value seen before the instruction
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pc_start_r <= WORD_RST;
      end else if (!busy_o) begin
         pc_start_r <= pc_o;
      end
   end

   sequence setup_s;
      psel_i && !penable_i;
   endsequence
   sequence access_s;
      psel_i && penable_i;
   endsequence
   sequence group2_wr_s;
      pready_o && pwrite_i && !pslverr_o && paddr_i == INSTR_OFS && pwdata_i[11:8] == 4'h3;
   endsequence

   wait_state_a: assert property (setup_s ##1 access_s |=> pready_o) // One wait state
      else $error("answer not one cycle after access");
   ready_pulse_a: assert property (pready_o |=> !pready_o) // Single cycle
      else $error("ready held too long");
   err_qual_a: assert property (pslverr_o |-> pready_o && psel_i && penable_i) // Error framing
      else $error("error outside access");
   unmapped_err_a: assert property (pready_o && !mapped |-> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped address accepted");
   busy_refuse_a: assert property (pready_o && pwrite_i && $past(busy_o) |-> pslverr_o)
      else $error("write while busy accepted");
   instr_start_a: assert property (group2_wr_s |=> busy_o)
      else $error("operate word did not start");
   busy_bound_a: assert property ($rose(busy_o) |-> ##[1:BUSY_MAX] !busy_o) // Bounded run
      else $error("instruction never finished");
   pc_step_a: assert property ($fell(busy_o) |-> (pc_o - pc_start_r) inside {12'h001, 12'h002})
      else $error("counter advance not one or two");
   pc_hold_a: assert property (!busy_o && !pready_o |=> $stable(pc_o))
      else $error("counter moved while idle");
   rd_width_a: assert property (pready_o && !pwrite_i |-> prdata_o[31:12] == 20'h0) // Width
      else $error("read data upper bits set");
endmodule : operate_asserts

bind accumulator_operate_decode operate_asserts #(.STEP_DIV(STEP_DIV)) asserts_i (
   .ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
   .prdata_o, .pready_o, .pslverr_o, .busy_o, .pc_o);

// >>> sim/apb_host.sv
`timescale 1ns/1ps
module apb_host
   import operate_pkg::*;
(
   input  logic                           ref_clk_i,
   input  logic [31:0]                    prdata_i,
   input  logic                           pready_i,
   input  logic                           pslverr_i,
   output logic                           psel_o,
   output logic                           penable_o,
   output logic                           pwrite_o,
   output logic [operate_pkg::ADDR_W-1:0] paddr_o,
   output logic [31:0]                    pwdata_o
);
   // Idle bus at time zero
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = '0;
      pwdata_o = '0;
   end

   // One transfer, held until ready is sampled
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge ref_clk_i);
      psel_o <= 1'b1;
      pwrite_o <= wr;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge ref_clk_i);
      penable_o <= 1'b1;
      // Ready ends this wait; only the bench's cycle ceiling bounds it
      do begin
         @(posedge ref_clk_i);
      end while (pready_i !== 1'b1);
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      paddr_o <= ~a; // Released lines show no stale value
      pwdata_o <= ~d;
   endtask : xfer
endmodule : apb_host

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
   import operate_pkg::*;
   localparam int STEP = 2;
   logic              ref_clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              psel, penable, pwrite, pready, pslverr, busy, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rdat;
   logic [WORD_W-1:0] pc, pc0;
   int                n_fail = 0;
   int                checked = 0;
   int                cyc = 0;

   always #2.5 ref_clk = ~ref_clk;

   accumulator_operate_decode #(.STEP_DIV(STEP)) accumulator_operate_decode_i (
      .ref_clk_i(ref_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .busy_o(busy), .pc_o(pc));
   apb_host host_i (
      .ref_clk_i(ref_clk), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
      .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
      .pwdata_o(pwdata));

   task automatic report_and_stop;
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      host_i.xfer(1'b1, a, d, rdat, err);
   endtask : wr

   task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e);
      host_i.xfer(1'b0, a, 32'h0, rdat, err);
      chk(what, e, rdat);
   endtask : rdchk

   // Start an instruction and wait for the end
   task automatic run(input logic [11:0] ins);
      pc0 = pc;
      wr(INSTR_OFS, {20'h0, ins});
      repeat (2) @(posedge ref_clk);
      while (busy !== 1'b0) begin
         @(posedge ref_clk);
      end
      @(negedge ref_clk);
   endtask : run

   // Row: word, first, second, expected first, expected second, pc step
   task automatic do_row(input logic [71:0] r);
      wr(ACC1_OFS, {20'h0, r[59:48]});
      wr(ACC2_OFS, {20'h0, r[47:36]});
      run(r[71:60]);
      chk("pc step", {20'h0, r[11:0]}, {20'h0, pc - pc0});
      rdchk("first acc", ACC1_OFS, {20'h0, r[35:24]});
      rdchk("second acc", ACC2_OFS, {20'h0, r[23:12]});
   endtask : do_row

   task automatic t_reset;
      chk("pc", 32'h0, {20'h0, pc});
      for (int a = 0; a <= 16; a += 4) begin
         rdchk("reset value", a[7:0], 32'h0);
      end
   endtask : t_reset

   task automatic t_modify;
      logic [71:0] t [13] = '{
         72'h344005000006000001, 72'h344fff000000000001, // increment
         72'h384000_7ff000800001, 72'h348123456000456001, // increment second, clear first
         72'h3500f0000f0f000001, 72'h354001000fff000001, // complement, negate
         72'h394000000000000001, 72'h358123456fff456001, // negate second, set first
         72'h3c8123456000000001, 72'h3d8123456ffffff001, // both
         72'h3d000ff00ff00ff001, 72'h300321654321654001, // complement both, idle
         72'h310321654321654001};                          // flag only
      for (int i = 0; i < 13; i++) begin
         do_row(t[i]);
      end
   endtask : t_modify

   task automatic t_skip;
      logic [71:0] t [10] = '{
         72'h341000000000000001, 72'h341005000005000002, // nonzero
         72'h345000000000000002, 72'h345001000001000001, // zero
         72'h3427ff0007ff000002, 72'h342800000800000001, // sign
         72'h346800000800000002, 72'h3c5000000000000002, // reversed
         72'h3c5000001000001001, 72'h381000003000003002};
      for (int i = 0; i < 10; i++) begin
         do_row(t[i]);
      end
   endtask : t_skip

   task automatic t_status;
      logic [19:0] t [9] = '{20'h31811, 20'h33831, 20'h30531, 20'h30821, 20'h33001,
                             20'h32502, 20'h30101, 20'h31011, 20'h30112};
      wr(STATUS_OFS, 32'h0);
      for (int i = 0; i < 9; i++) begin
         run(t[i][19:8]);
         chk("pc step", {28'h0, t[i][3:0]}, {20'h0, pc - pc0});
         host_i.xfer(1'b0, STATUS_OFS, 32'h0, rdat, err);
         chk("status", {28'h0, t[i][7:4]}, {30'h0, rdat[1:0]});
      end
   endtask : t_status

   task automatic t_refuse;
      do_row(72'hb44005000005000001);
      rdchk("not group two", STATUS_OFS, 32'h11);
      wr(ACC1_OFS, 32'h5);
      wr(INSTR_OFS, 32'h344);
      wr(ACC1_OFS, 32'h777);
      chk("busy write error", 32'h1, {31'h0, err});
      run(12'h300);
      rdchk("first acc", ACC1_OFS, 32'h6);
      wr(8'h14, 32'h1);
      chk("unmapped error", 32'h1, {31'h0, err});
   endtask : t_refuse

   initial begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_modify();
      t_skip();
      t_status();
      t_refuse();
      report_and_stop();
   end
endmodule : tb
